// ---- hw/sbf_frame.v ----
// Serial link transaction framer: header decode, burst data words, register strobes.
// Assumes serial mode 0 (sample on rising clock, shift on falling) from the host,
// and register read data returned within a few clocks of the read strobe.
// Limitation: each link clock phase must last several clocks, or its edges are missed.
//
// Overview of operation
// [RULE_01] Chip select assertion starts a frame; first 32 bits are the header.
// [RULE_02] Header carries read/write command, start address and word count.
// [RULE_03] Data then moves in 32-bit words, exactly the header's count.
// [RULE_04] Host keeps chip select low between all words of one frame.
// [RULE_05] Chip select release ends the frame and reports completion.
// [RULE_06] Word count field 0..255, with zero meaning 256 words.
// [RULE_07] Host holds chip select for at least header plus one word.
// [RULE_08] Register address steps by one word for each further data word.
`timescale 1ns/1ps
`default_nettype none
`include "sbf_defs.vh"

module sbf_frame #(
    parameter ADDR_W = 16
) (
    input  wire              clock,
    input  wire              arst_n,
    input  wire              sclk,
    input  wire              csN,
    input  wire              mosi,
    output wire              miso,
    output reg               misoEn,
    output reg  [ADDR_W-1:0] regAddr,
    output reg               regWrite,
    output reg  [31:0]       regWrData,
    output reg               regRead,
    input  wire [31:0]       regRdData,
    input  wire              regRdValid,
    output reg               done,
    output reg               doneErr
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_HDR   = 3'h1;
    localparam ST_WR    = 3'h2;
    localparam ST_RD    = 3'h3;
    localparam ST_DRAIN = 3'h4;

    wire [2:0] pinSync;
    wire       sclkS;
    wire       csS;
    wire       mosiS;

    // Chip select resets high so a frame is never seen during reset
    sbf_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h2)
    ) uSync (
        .clock  (clock),
        .arst_n (arst_n),
        .din    ({mosi, csN, sclk}),
        .dout   (pinSync)
    );
    assign sclkS = pinSync[0];
    assign csS   = pinSync[1];
    assign mosiS = pinSync[2];

    reg              sclkPrev;
    reg              csPrev;
    reg  [2:0]       state;
    reg  [31:0]      shiftIn;
    reg  [4:0]       bitCnt;
    reg  [8:0]       wordsLeft;
    reg  [ADDR_W-1:0] addr;
    reg              overrun;
    reg  [31:0]      misoShift;
    reg  [1:0]       wordsSeen;

    wire             csStart = ~csS & csPrev;
    wire             csEnd   = csS & ~csPrev;
    wire             rise    = sclkS & ~sclkPrev & ~csS;
    wire             fall    = ~sclkS & sclkPrev & ~csS;
    wire             wordEnd = rise & (bitCnt == 5'h1F);
    wire [31:0]      next_shiftIn = {shiftIn[30:0], mosiS};
    wire [7:0]       hdrCmd  = next_shiftIn[`SBF_HDR_CMD_MSB:`SBF_HDR_CMD_LSB];
    wire [7:0]       hdrCnt  = next_shiftIn[`SBF_HDR_CNT_MSB:`SBF_HDR_CNT_LSB];
    wire [ADDR_W-1:0] hdrAddr =
        next_shiftIn[`SBF_HDR_ADDR_LSB+ADDR_W-1:`SBF_HDR_ADDR_LSB];
    wire [ADDR_W-1:0] addrNext = addr + {{(ADDR_W-1){1'b0}}, 1'b1};
    // Reasons for a failed frame, kept apart so each can be probed on its own
    wire             errCmd     = (state == ST_HDR) | (state == ST_DRAIN);
    wire             errCount   = (wordsLeft != 9'h000);
    wire             errPartial = (bitCnt != 5'h00);
    wire             errShort   = (wordsSeen != `SBF_MIN_FRAME_WORDS);
    // A read word loads when its answer arrives and shifts on counted falls only
    wire             rdLoad     = regRdValid & (state == ST_RD);
    wire             rdShift    = fall & (state == ST_RD) & (bitCnt != 5'h00);

    assign miso = misoShift[31];

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclkPrev  <= 1'b0;
            csPrev    <= 1'b1;
            misoEn    <= 1'b0;
            state     <= ST_IDLE;
            shiftIn   <= 32'h00000000;
            bitCnt    <= 5'h00;
            wordsLeft <= 9'h000;
            addr      <= {ADDR_W{1'b0}};
            overrun   <= 1'b0;
            regAddr   <= {ADDR_W{1'b0}};
            regWrite  <= 1'b0;
            regWrData <= 32'h00000000;
            regRead   <= 1'b0;
            done      <= 1'b0;
            doneErr   <= 1'b0;
        end else begin
            sclkPrev <= sclkS;
            csPrev   <= csS;
            misoEn   <= ~csS;
            regWrite <= 1'b0;
            regRead  <= 1'b0;
            done     <= 1'b0;
            if (csStart) begin
                state     <= ST_HDR;                                 // [RULE_01]
                bitCnt    <= 5'h00;
                wordsLeft <= 9'h000;
                overrun   <= 1'b0;
            end else if (csEnd) begin
                // Short, partial, missing or surplus words all flag the frame
                done    <= (state != ST_IDLE);                       // [RULE_05]
                doneErr <= errCmd | errCount | errPartial | errShort |
                           overrun;                                  // [RULE_07]
                state   <= ST_IDLE;
            end else if (rise) begin
                shiftIn <= next_shiftIn;
                bitCnt  <= bitCnt + 5'h01;
                if (wordEnd) begin
                    case (state)
                        ST_HDR: begin
                            addr      <= hdrAddr;                    // [RULE_02]
                            regAddr   <= hdrAddr;
                            wordsLeft <= (hdrCnt == 8'h00) ? `SBF_CNT_ZERO_WORDS :
                                         {1'b0, hdrCnt};             // [RULE_06]
                            if (hdrCmd == `SBF_CMD_WRITE) begin
                                state <= ST_WR;
                            end else if (hdrCmd == `SBF_CMD_READ) begin
                                state   <= ST_RD;
                                regRead <= 1'b1;
                            end else begin
                                // Unknown command: clocked through, no register access
                                state <= ST_DRAIN;
                            end
                        end
                        ST_WR: begin
                            if (wordsLeft != 9'h000) begin
                                regWrite  <= 1'b1;                   // [RULE_03]
                                regWrData <= next_shiftIn;
                                regAddr   <= addr;
                                addr      <= addrNext;               // [RULE_08]
                                wordsLeft <= wordsLeft - 9'h001;
                            end else begin
                                overrun <= 1'b1;                     // [RULE_03]
                            end
                        end
                        ST_RD: begin
                            if (wordsLeft != 9'h000) begin
                                wordsLeft <= wordsLeft - 9'h001;     // [RULE_03]
                                addr      <= addrNext;               // [RULE_08]
                                if (wordsLeft != 9'h001) begin
                                    regRead <= 1'b1;
                                    regAddr <= addrNext;
                                end
                            end else begin
                                overrun <= 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // Read word loads when its answer arrives after a word boundary; no shift on the falling edge that follows that boundary,
    // so the first bit stays on the pin until the host samples it
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            misoShift <= 32'h00000000;
        end else if (csStart || csEnd) begin
            // Cleared at both frame edges so the pin rests low outside read data
            misoShift <= 32'h00000000;
        end else if (rdLoad) begin
            misoShift <= regRdData;                                  // [RULE_03]
        end else if (rdShift) begin
            misoShift <= {misoShift[30:0], 1'b0};
        end
    end

    // Whole words seen in this frame, saturating at the legal minimum of header plus one
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wordsSeen <= 2'h0;
        end else if (csStart) begin
            wordsSeen <= 2'h0;
        end else if (wordEnd && wordsSeen != `SBF_MIN_FRAME_WORDS) begin
            wordsSeen <= wordsSeen + 2'h1;                           // [RULE_07]
        end
    end
endmodule // sbf_frame

`default_nettype wire

// ---- hw/sbf_defs.vh ----
// Constants for the serial burst transaction framer.
// Included by the framer and its synchroniser; definitions only.
`ifndef SBF_DEFS_VH
`define SBF_DEFS_VH

`define SBF_WORD_BITS      32
`define SBF_HDR_CMD_MSB    31
`define SBF_HDR_CMD_LSB    24
`define SBF_HDR_ADDR_MSB   23
`define SBF_HDR_ADDR_LSB   8
`define SBF_HDR_CNT_MSB    7
`define SBF_HDR_CNT_LSB    0
`define SBF_CMD_WRITE      8'h01
`define SBF_CMD_READ       8'h02
`define SBF_CNT_ZERO_WORDS 9'h100
`define SBF_MIN_FRAME_WORDS 2'h2
`define SBF_SYNC_STAGES    2

`endif

// ---- hw/sbf_sync.v ----
// Two-stage synchroniser bank, one chain per bit.
// Inputs are asynchronous pins; outputs are on clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbf_defs.vh"

module sbf_sync #(
    parameter WIDTH     = 3,
    parameter RESET_VAL = 3'h0
) (
    input  wire             clock,
    input  wire             arst_n,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gChain
            reg stage1;
            reg stage2;
            // Stage one feeds stage two only
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    stage1 <= RESET_VAL[i];
                    stage2 <= RESET_VAL[i];
                end else begin
                    stage1 <= din[i];
                    stage2 <= stage1;
                end
            end
            assign dout[i] = stage2;
        end
    endgenerate
endmodule // sbf_sync

`default_nettype wire

// ---- dv/sbf_frame_checker.sv ----
// Port checker for sbf_frame.
// Bound by name into every sbf_frame; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sbf_frame_checker #(parameter ADDR_W = 16) (
    input wire logic              clock,
    input wire logic              arst_n,
    input wire logic              csN,
    input wire logic              misoEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic              regWrite,
    input wire logic [31:0]       regWrData,
    input wire logic              regRead,
    input wire logic              done,
    input wire logic              doneErr
);
    logic              seen;
    logic [ADDR_W-1:0] lastA;
    // Tracks the previous strobe address inside one frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seen  <= 1'b0;
            lastA <= '0;
        end else begin
            if (regWrite || regRead) lastA <= regAddr;
            if (done) seen <= 1'b0;
            else if (regWrite || regRead) seen <= 1'b1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_wr_gap; regWrite |=> !regWrite [*8]; endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write gap");
    property p_rd_gap; regRead |=> !regRead [*8]; endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read gap");
    property p_in_frame; regWrite || regRead |-> misoEn; endproperty
    a_in_frame: assert property (p_in_frame) else $error("strobe idle");
    property p_done; $rose(csN) |-> ##[1:8] done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_step; (regWrite || regRead) && seen |-> regAddr == lastA + 1'b1; endproperty
    a_step: assert property (p_step) else $error("address step");
    property p_wr_hold; regWrite |=> $stable(regWrData) [*8]; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("data hold");
    property p_rd_excl; regRead |-> !regWrite; endproperty
    a_rd_excl: assert property (p_rd_excl) else $error("both strobes");
    property p_err_hold; !done |-> $stable(doneErr); endproperty
    a_err_hold: assert property (p_err_hold) else $error("status moved");
    c_wr: cover property (regWrite);
    c_rd: cover property (regRead);
    c_err: cover property (done && doneErr);
endmodule // sbf_frame_checker
bind sbf_frame sbf_frame_checker #(.ADDR_W(ADDR_W)) i_chk (.*);
`default_nettype wire

// ---- dv/sbf_host.sv ----
// Host model: mode 0 frames, MSB first, 160 ns bit period.
// Clock idles low; select and data are driven by task calls only.
`timescale 1ns/1ps
`default_nettype none
module sbf_host (
    output var logic sclk,
    output var logic csN,
    output var logic mosi,
    input wire logic miso
);
    logic [31:0] txq[$];
    logic [31:0] rxq[$];
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        mosi = 1'b0;
    end
    task automatic frame(input logic [31:0] hdr, input int nw);
        logic [31:0] w;
        logic [31:0] r;
        csN = 1'b0;
        #200;
        for (int k = 0; k <= nw; k++) begin
            w = (k == 0) ? hdr : txq.pop_front();
            for (int b = 31; b >= 0; b--) begin
                mosi = w[b];
                #80 sclk = 1'b1;
                r[b] = miso;
                #80 sclk = 1'b0;
            end
            if (k > 0) rxq.push_back(r);
            #400;
        end
        csN = 1'b1;
        mosi = ~mosi; // Released line must not keep the last bit
        #400;
    endtask
endmodule // sbf_host
`default_nettype wire

// ---- dv/sbf_frame_test.sv ----
// Self-checking bench for sbf_frame with host model and read responder.
// Assumes the link runs far slower than the 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbf_defs.vh"
module sbf_frame_test;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic sclk, csN, mosi, miso, misoEn, regWrite, regRead, done, doneErr;
    logic regRdValid = 1'b0;
    logic [15:0] regAddr, rdA;
    logic [31:0] regWrData, d;
    logic [31:0] regRdData = '0;
    logic [49:0] expQ[$];
    logic [49:0] obs;
    int err_total = 0;
    int n_compared = 0;
    int seed = 49651;
    int cyc = 0;
    sbf_frame i_dut (.*);
    sbf_host i_host (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
    always #5 clock = ~clock;
    task automatic check(input logic [49:0] e, input logic [49:0] o);
        n_compared++;
        if (o !== e) begin
            err_total++;
            $display("CHECK FAILED %0t exp %h got %h", $time, e, o);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Read data answered 1..4 clocks after the strobe, tagged with its address
    always @(negedge clock) if (regRead === 1'b1) begin
        rdA = regAddr;
        repeat ($random(seed) & 3) @(posedge clock);
        @(posedge clock) #1 regRdData = {16'hA5A5, rdA};
        regRdValid = 1'b1;
        @(posedge clock) #1 regRdValid = 1'b0;
    end
    // Strobes are looked at mid-cycle, where they stand settled
    always @(negedge clock) if ((regWrite | regRead | done) === 1'b1) begin
        obs = regWrite ? {2'd1, regAddr, regWrData} :
              regRead ? {2'd2, regAddr, 32'h0} : {2'd3, 47'h0, doneErr};
        check(expQ.size() ? expQ.pop_front() : '1, obs);
        if (regWrite | regRead) check(50'(misoEn), 50'h1);
    end
    always @(posedge clock) if (++cyc == 30000) begin
        err_total++;
        $display("CHECK FAILED %0t timeout", $time);
        end_sim();
    end
    task automatic run(input logic [7:0] cmd, input int cnt, input int nw, input logic er);
        int eff;
        logic [15:0] a;
        eff = (cnt == 0) ? 256 : cnt;
        a = 16'($random(seed));
        for (int k = 0; k < nw; k++) begin
            d = $random(seed);
            i_host.txq.push_back(d);
            if (k < eff && cmd == `SBF_CMD_WRITE) expQ.push_back({2'd1, a + 16'(k), d});
            if (k < eff && cmd == `SBF_CMD_READ) expQ.push_back({2'd2, a + 16'(k), 32'h0});
        end
        expQ.push_back({2'd3, 47'h0, er});
        i_host.rxq.delete(); // Words clocked back in earlier write frames are not read data
        @(posedge clock) #1 i_host.frame({cmd, a, 8'(cnt)}, nw);
        repeat (20) @(posedge clock);
        check(50'(misoEn), 50'h0);
        for (int k = 0; k < nw && cmd == `SBF_CMD_READ; k++)
            check({18'h0, i_host.rxq.pop_front()}, {18'h0, 16'hA5A5, a + 16'(k)});
        $display("test cmd %h count %0d words %0d finished", cmd, cnt, nw);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clock);
        run(`SBF_CMD_WRITE, 1, 1, 1'b0);
        run(`SBF_CMD_WRITE, 3, 3, 1'b0);
        run(`SBF_CMD_READ, 2, 2, 1'b0);
        run(`SBF_CMD_READ, 1, 1, 1'b0);
        run(`SBF_CMD_WRITE, 0, 3, 1'b1);
        run(`SBF_CMD_WRITE, 1, 2, 1'b1);
        run(8'h03, 1, 1, 1'b1);
        run(`SBF_CMD_WRITE, 1, 0, 1'b1);
        check(50'(expQ.size()), 50'h0);
        end_sim();
    end
endmodule // sbf_frame_test
`default_nettype wire
